// [verif/wdtu_testbench.sv]
module testbench
    import wdtu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4; // short oscillator period keeps runs brief
    logic          clk_sys = 1'b0;
    logic          arst_n  = 1'b0;
    wdtu_cfg_t     cfg     = 8'h40;
    wdtu_cpu_evt_t evt     = '0;
    wdtu_axi_req_t axi_q   = '0;
    wdtu_axi_rsp_t axi_s;
    logic          wd_rst, wake, rco_en, irq;
    logic [1:0]    ev;                   // {reset, wake} seen
    logic [7:0]    cfgs [3] = '{8'h40, 8'h51, 8'h43};
    int            n, i, tmo, num_errors, cmp_count;

    wdtu_watchdog_timer #(.RCO_DIV(DIV)) u_wdtu_watchdog_timer (
        .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_cfg(cfg),
        .i_evt(evt), .i_axi(axi_q), .o_axi(axi_s), .o_wd_reset(wd_rst),
        .o_wake(wake), .o_rco_en(rco_en), .o_irq(irq));

    // 100 MHz system clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // straps only change while reset is held, as the core captures once
    task automatic do_reset(input logic [7:0] c);
        arst_n <= 1'b0;
        cfg    <= c;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk_sys);
        axi_q.awvalid <= 1'b1;
        axi_q.awaddr  <= a;
        axi_q.wvalid  <= 1'b1;
        axi_q.wdata   <= d;
        axi_q.wstrb   <= 4'hf;
        axi_q.bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_s.awready)
                axi_q.awvalid <= 1'b0;
            if (axi_s.wready)
                axi_q.wvalid <= 1'b0;
        end while (axi_s.bvalid !== 1'b1);
        axi_q.bready <= 1'b0;
        check(axi_s.bresp, r);
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] r);
        @(posedge clk_sys);
        axi_q.arvalid <= 1'b1;
        axi_q.araddr  <= a;
        axi_q.rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_s.arready)
                axi_q.arvalid <= 1'b0;
        end while (axi_s.rvalid !== 1'b1);
        axi_q.rready <= 1'b0;
        check(axi_s.rdata, e);
        check(axi_s.rresp, r);
    endtask : chk_rd

    // one-cycle core event, bits as in the event struct
    task automatic pulse(input logic [5:0] e);
        @(posedge clk_sys);
        evt <= wdtu_cpu_evt_t'(e);
        @(posedge clk_sys);
        evt <= '0;
    endtask : pulse

    // bounded wait for reset or wake, n counts the cycles taken
    task automatic wait_ev();
        ev = 2'h0;
        for (n = 0; n < 3000 && ev == 2'h0; n++) begin
            @(posedge clk_sys);
            ev = {wd_rst, wake};
        end
    endtask : wait_ev

    task automatic close_out();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    initial begin
        // period per prescale and postscale, restarted by a clear
        for (i = 0; i < 3; i++) begin
            do_reset(cfgs[i]);
            tmo = ((cfgs[i][4] ? 128 : 32) << cfgs[i][3:0]) * DIV;
            chk_rd(REG_CONFIG, {24'h0, cfgs[i]}, RESP_OKAY);
            check(rco_en, 1'b0);
            wr(REG_RESET_CAUSE, 32'h20, RESP_OKAY);
            // enable is registered one edge after the write answer
            @(posedge clk_sys);
            check(rco_en, 1'b1);
            repeat (tmo / 2) @(posedge clk_sys);
            // middle pass restarts through a finished clock switch
            pulse(i == 1 ? 6'h20 : 6'h04);
            wait_ev();
            check(ev, 2'b10);
            check(n >= tmo - 8 && n <= tmo + 8, 1'b1);
        end
        $display("test timeout periods done");
        // system answers with a device reset; flags and interrupt
        pulse(6'h01);
        chk_rd(REG_RESET_CAUSE, 32'h10, RESP_OKAY);
        chk_rd(REG_COUNT, 32'h0, RESP_OKAY);
        check(rco_en, 1'b0);
        check(irq, 1'b0);
        wr(REG_IRQ_MASK, 32'h7, RESP_OKAY);
        @(posedge clk_sys);
        check(irq, 1'b1);
        chk_rd(REG_IRQ_STATUS, 32'h1, RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        check(irq, 1'b0);
        wr(8'h20, 32'h1, RESP_SLVERR);
        chk_rd(8'h20, 32'h0, RESP_SLVERR);
        chk_rd(REG_IRQ_MASK, 32'h7, RESP_OKAY);
        $display("test flags and interrupt done");
        // sleep then idle: timeout only wakes, flags stay for software
        wr(REG_RESET_CAUSE, 32'h20, RESP_OKAY);
        for (i = 0; i < 2; i++) begin
            pulse(i ? 6'h08 : 6'h10);
            wait_ev();
            check(ev, 2'b01);
            check(n >= tmo - 8 && n <= tmo + 8, 1'b1);
            chk_rd(REG_RESET_CAUSE, i ? 32'h34 : 32'h38, RESP_OKAY);
            wr(REG_RESET_CAUSE, 32'h20, RESP_OKAY);
        end
        // another wake source restarts the count, then a reset follows
        pulse(6'h10);
        repeat (tmo / 2) @(posedge clk_sys);
        pulse(6'h02);
        wait_ev();
        check(ev, 2'b10);
        check(n >= tmo - 8 && n <= tmo + 8, 1'b1);
        $display("test sleep and idle done");
        // fixed enable with window: early clear resets at once
        do_reset(8'h80);
        check(rco_en, 1'b1);
        wr(REG_RESET_CAUSE, 32'h0, RESP_OKAY);
        check(rco_en, 1'b1);
        pulse(6'h04);
        wait_ev();
        check(ev, 2'b10);
        check(n < 4, 1'b1);
        chk_rd(REG_RESET_CAUSE, 32'h10, RESP_OKAY);
        $display("test window done");
        close_out();
    end

    // hang guard, runs are about 7k cycles
    initial begin
        #200us;
        num_errors++;
        close_out();
    end
endmodule : testbench

// [verif/wdtu_watchdog_timer_monitor.sv]
module wdtu_watchdog_timer_monitor
    import wdtu_pkg::*;
(
    // clock and reset
    input wire logic          i_clk_sys,
    input wire logic          i_arst_n,
    // inputs of the watchdog
    input wire wdtu_cfg_t     i_cfg,
    input wire wdtu_cpu_evt_t i_evt,
    input wire wdtu_axi_req_t i_axi,
    // outputs of the watchdog
    input wire wdtu_axi_rsp_t o_axi,
    input wire logic          o_wd_reset,
    input wire logic          o_wake,
    input wire logic          o_rco_en,
    input wire logic          o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mon_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    logic asleep;      // core parked in sleep or idle
    logic next_asleep; // follows power-save and wake pulses

    // power mode seen from the event pulses, wake wins over entry
    always_comb begin
        next_asleep = asleep;
        if (i_evt.psave_sleep || i_evt.psave_idle)
            next_asleep = 1'b1;
        if (o_wake || i_evt.wake_event || i_evt.dev_rst)
            next_asleep = 1'b0;
    end

    // mode flop, cleared with the block
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n)
            asleep <= 1'b0;
        else
            asleep <= next_asleep;
    end

    sequence fire_s;
        o_wd_reset || o_wake;
    endsequence
    sequence ar_take_s;
        i_axi.arvalid && o_axi.arready;
    endsequence
    sequence wr_take_s;
        i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
    endsequence

    pulse_once_a: assert property (fire_s |=> !o_wd_reset && !o_wake)
        else $error("watchdog action lasted past one cycle");
    one_action_a: assert property (!(o_wd_reset && o_wake))
        else $error("reset and wake raised together");
    needs_enable_a: assert property (fire_s |-> $past(o_rco_en))
        else $error("watchdog acted while disabled");
    fixed_on_a: assert property (
        o_rco_en && i_cfg.fixed_watchdog_enable |=> o_rco_en)
        else $error("fixed enable watchdog switched off");
    soft_clear_a: assert property (
        i_evt.dev_rst && !i_cfg.fixed_watchdog_enable |-> ##[1:2] !o_rco_en)
        else $error("soft enable survived a device reset");
    wake_sleep_a: assert property (o_wake |-> asleep)
        else $error("wake raised while running");
    run_reset_a: assert property (o_wd_reset |-> !asleep)
        else $error("reset raised in sleep or idle");
    rd_answer_a: assert property (ar_take_s |=> o_axi.rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (wr_take_s |-> ##2 o_axi.bvalid)
        else $error("write answer late");
endmodule : wdtu_watchdog_timer_monitor

bind wdtu_watchdog_timer wdtu_watchdog_timer_monitor u_wdtu_mon (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cfg(i_cfg),
    .i_evt(i_evt), .i_axi(i_axi), .o_axi(o_axi), .o_irq(o_irq),
    .o_wd_reset(o_wd_reset), .o_wake(o_wake), .o_rco_en(o_rco_en)
);

// [verilog/wdtu_low_power_rc_osc_osc.sv]
// emulated low-power rc oscillator: one tick per nominal period
module wdtu_rc_osc
    import wdtu_pkg::*;
#(
    parameter int unsigned DIV = RCO_DIV_CYCLES
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_arst_n,
    // control
    input  wire logic i_enable,
    // output tick
    output logic      o_tick
);

    localparam int unsigned CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;   // position within one period
        logic          tick;  // one-cycle pulse per period
    } wdtu_osc_state_t;

    wdtu_osc_state_t s;       // registered state
    wdtu_osc_state_t next_s;  // next state

    // divider runs only while enabled, so a disabled watchdog costs nothing
    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (!i_enable) begin
            next_s.cnt = '0;
        end else if (s.cnt == LAST) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
    end

    // state register
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_tick = s.tick;

endmodule : wdtu_rc_osc

// [verilog/wdtu_pkg.sv]
package wdtu_pkg;

    // timing: system clock and nominal watchdog oscillator rate
    localparam int unsigned SYS_CLK_HZ       = 100_000_000;
    localparam int unsigned RCO_FREQ_HZ      = 32_767;    // 32.767 kHz
    // one oscillator period in system cycles, rounded down
    localparam int unsigned RCO_DIV_CYCLES   = SYS_CLK_HZ / RCO_FREQ_HZ;

    // prescaler ratios and the base timeout they give
    localparam int unsigned PRE_DIV_SHORT    = 32;
    localparam int unsigned PRE_DIV_LONG     = 128;
    localparam int unsigned BASE_TMO_SHORT_MS = 1;
    localparam int unsigned BASE_TMO_LONG_MS  = 4;
    // longest reachable timeout, 4 ms times 1:32,768
    localparam int unsigned MAX_TMO_S        = 131;

    // counter widths
    localparam int unsigned POST_SEL_W       = 4;
    localparam int unsigned PRE_CNT_W        = 7;
    localparam int unsigned POST_CNT_W       = 15;
    localparam logic [PRE_CNT_W-1:0] PRE_LAST_SHORT =
        PRE_CNT_W'(PRE_DIV_SHORT - 1);
    localparam logic [PRE_CNT_W-1:0] PRE_LAST_LONG  =
        PRE_CNT_W'(PRE_DIV_LONG - 1);

    // cycles the configuration straps settle before capture
    localparam logic [1:0]  CFG_SETTLE_CYCLES = 2'h3;

    // register map, byte addresses
    localparam int unsigned ADDR_W           = 8;
    localparam logic [7:0]  REG_RESET_CAUSE  = 8'h00;
    localparam logic [7:0]  REG_CONFIG       = 8'h04;
    localparam logic [7:0]  REG_COUNT        = 8'h08;
    localparam logic [7:0]  REG_IRQ_STATUS   = 8'h0c;
    localparam logic [7:0]  REG_IRQ_MASK     = 8'h10;

    // reset_cause_reg field positions
    localparam int unsigned RC_SOFT_EN_BIT   = 5;
    localparam int unsigned RC_TIMEOUT_BIT   = 4;
    localparam int unsigned RC_SLEEP_BIT     = 3;
    localparam int unsigned RC_IDLE_BIT      = 2;

    // interrupt status and mask layout
    localparam int unsigned IRQ_W            = 3;
    localparam int unsigned IRQ_TIMEOUT_BIT  = 0;
    localparam int unsigned IRQ_EARLY_BIT    = 1;
    localparam int unsigned IRQ_WAKE_BIT     = 2;

    // values after reset
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [7:0]  CFG_RST          = 8'h00;

    // bus answers
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // watchdog_config_word layout, bit 7 down to bit 0
    typedef struct packed {
        logic                  fixed_watchdog_enable; // bit 7
        logic                  window_disable;        // bit 6
        logic                  spare;                 // bit 5
        logic                  prescale_select;       // bit 4, 1 = /128
        logic [POST_SEL_W-1:0] postscale_select;      // bits 3:0
    } wdtu_cfg_t;

    // one-cycle events from the core
    typedef struct packed {
        logic clk_switch_done;  // clock switch finished
        logic psave_sleep;      // power_save_instr, sleep
        logic psave_idle;       // power_save_instr, idle
        logic wd_clear;         // watchdog_clear_instr
        logic wake_event;       // other wake source left sleep or idle
        logic dev_rst;          // any device reset
    } wdtu_cpu_evt_t;

    // power mode of the device as the watchdog sees it
    typedef enum logic [2:0] {
        PM_RUN   = 3'b001,
        PM_SLEEP = 3'b010,
        PM_IDLE  = 3'b100
    } wdtu_pmode_t;

    // axi4-lite master to slave
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } wdtu_axi_req_t;

    // axi4-lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wdtu_axi_rsp_t;

endpackage : wdtu_pkg

// [verilog/wdtu_watchdog_timer.sv]
// Overview of operation
// - watchdog clocked by rc oscillator, enabled together
// - prescaler divides by 32 or 128
// - base timeout 1 ms or 4 ms
// - 4-bit postscaler, ratios 1:1 to 1:32,768
// - timeouts span 1 ms to 131 s
// - completed clock switch clears all counters
// - entering sleep or idle clears counters
// - leaving sleep or idle clears counters
// - clear instruction clears counters while running
// - watchdog keeps counting in sleep and idle
// - timeout in sleep or idle only wakes
// - fixed enable bit forces watchdog permanently on
// - otherwise soft enable bit turns it on
// - device reset clears the soft enable
// - early clear outside last quarter resets
// - timeout flag sticks until software clears it
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
module wdtu_watchdog_timer
    import wdtu_pkg::*;
#(
    parameter int unsigned RCO_DIV = RCO_DIV_CYCLES
) (
    // clock and reset
    input  wire logic          i_clk_sys,
    input  wire logic          i_arst_n,
    // configuration straps and core events
    input  wire wdtu_cfg_t     i_cfg,
    input  wire wdtu_cpu_evt_t i_evt,
    // register bus
    input  wire wdtu_axi_req_t i_axi,
    output wdtu_axi_rsp_t      o_axi,
    // watchdog actions
    output logic               o_wd_reset,
    output logic               o_wake,
    output logic               o_rco_en,
    output logic               o_irq
);

    typedef struct packed {
        wdtu_cfg_t               cfg_meta;   // strap synchroniser, stage 1
        wdtu_cfg_t               cfg_sync;   // strap synchroniser, stage 2
        wdtu_cfg_t               cfg;        // captured config word
        logic [1:0]              cfg_cnt;    // settle counter
        logic                    cfg_valid;  // config captured
        wdtu_pmode_t             pmode;      // run, sleep or idle
        logic                    soft_en;    // soft_watchdog_enable
        logic                    flag_tmo;   // watchdog_timeout_flag
        logic                    flag_sleep; // woke from sleep
        logic                    flag_idle;  // woke from idle
        logic [PRE_CNT_W-1:0]    pre_cnt;    // prescaler count
        logic [POST_CNT_W-1:0]   post_cnt;   // postscaler count
        logic [IRQ_W-1:0]        irq_stat;   // sticky events
        logic [IRQ_W-1:0]        irq_mask;   // event enables
        logic                    wd_reset;   // reset request pulse
        logic                    wake;       // wake pulse
        logic                    rco_en;     // oscillator enable
        logic                    irq;        // interrupt level
        logic                    aw_got;     // write address held
        logic [ADDR_W-1:0]       awaddr;     // held write address
        logic                    w_got;      // write data held
        logic [31:0]             wdata;      // held write data
        logic [3:0]              wstrb;      // held byte strobes
        wdtu_axi_rsp_t           axi;        // bus outputs
    } wdtu_top_state_t;

    wdtu_top_state_t s;       // registered state
    wdtu_top_state_t next_s;  // next state
    logic            rco_tick;  // one pulse per oscillator period

    // last postscaler count for a 1:2^sel ratio
    function automatic logic [POST_CNT_W-1:0] post_last(
        input logic [POST_SEL_W-1:0] sel
    );
        logic [POST_CNT_W:0] ratio;
        ratio     = (POST_CNT_W+1)'(1) << sel;
        post_last = POST_CNT_W'(ratio - (POST_CNT_W+1)'(1));
    endfunction : post_last

    // word-aligned address compare
    function automatic logic addr_is(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0]        offs
    );
        addr_is = ({addr[ADDR_W-1:2], 2'h0} == offs);
    endfunction : addr_is

    // any mapped register
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        addr_mapped = addr_is(addr, REG_RESET_CAUSE) ||
                      addr_is(addr, REG_CONFIG) ||
                      addr_is(addr, REG_COUNT) ||
                      addr_is(addr, REG_IRQ_STATUS) ||
                      addr_is(addr, REG_IRQ_MASK);
    endfunction : addr_mapped

    // oscillator runs only while the watchdog does
    wdtu_rc_osc #(
        .DIV       (RCO_DIV)
    ) u_osc (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_enable  (s.rco_en),
        .o_tick    (rco_tick)
    );

    // combinational next state of the whole block
    always_comb begin
        logic                  wd_en;
        logic [PRE_CNT_W-1:0]  pre_last;
        logic [POST_CNT_W-1:0] plast;
        logic                  pre_tick;
        logic                  timeout;
        logic                  clr_run;
        logic                  early;
        logic                  clear_cnt;
        logic [21:0]           elapsed;
        logic [22:0]           period;
        logic [24:0]           el4;
        logic [24:0]           per3;
        logic                  win_open;
        logic [31:0]           rd;
        logic [IRQ_W-1:0]      ev;
        logic                  wr_rc;
        logic                  rd_clr;

        next_s           = s;
        next_s.wd_reset  = 1'b0;
        next_s.wake      = 1'b0;
        ev               = '0;
        wr_rc            = 1'b0;
        rd_clr           = 1'b0;
        rd               = 32'h0;

        // straps pass two flops, then are held once settled
        next_s.cfg_meta = i_cfg;
        next_s.cfg_sync = s.cfg_meta;
        if (!s.cfg_valid) begin
            next_s.cfg     = s.cfg_sync;
            next_s.cfg_cnt = s.cfg_cnt + 2'h1;
            if (s.cfg_cnt == CFG_SETTLE_CYCLES) begin
                next_s.cfg_valid = 1'b1;
            end
        end

        // fixed bit overrides the soft bit, so software cannot stop it
        wd_en = s.cfg_valid &&
                (s.cfg.fixed_watchdog_enable || s.soft_en);
        next_s.rco_en = wd_en;

        // prescaler wrap point chosen by prescale_select
        pre_last = s.cfg.prescale_select ? PRE_LAST_LONG
                                         : PRE_LAST_SHORT;
        plast    = post_last(s.cfg.postscale_select);
        pre_tick = wd_en && rco_tick && (s.pre_cnt == pre_last);
        // counting does not depend on power mode
        timeout  = pre_tick && (s.post_cnt == plast);

        // elapsed and full period in oscillator ticks
        if (s.cfg.prescale_select) begin
            elapsed = {s.post_cnt, s.pre_cnt};
            period  = {1'b0, 15'h0, 7'h0} +
                      ({8'h0, plast} + 23'h1) * 23'(PRE_DIV_LONG);
        end else begin
            elapsed = {2'h0, s.post_cnt, s.pre_cnt[4:0]};
            period  = ({8'h0, plast} + 23'h1) * 23'(PRE_DIV_SHORT);
        end
        el4      = {1'b0, elapsed, 2'h0};
        per3     = {2'h0, period} + {1'b0, period, 1'b0};
        // open once three quarters of the period have gone by
        win_open = (el4 >= per3);

        // clear instruction only counts during normal execution
        clr_run = i_evt.wd_clear && (s.pmode == PM_RUN);
        early   = clr_run && wd_en && !s.cfg.window_disable &&
                  !win_open;

        // counters restart on every clearing event
        clear_cnt = !wd_en || timeout || i_evt.dev_rst ||
                    i_evt.clk_switch_done ||
                    clr_run;

        // power mode sequencing
        unique case (s.pmode)
            PM_RUN: begin
                if (i_evt.psave_sleep) begin
                    next_s.pmode      = PM_SLEEP;
                    next_s.flag_sleep = 1'b1;
                    clear_cnt         = 1'b1;
                end else if (i_evt.psave_idle) begin
                    next_s.pmode     = PM_IDLE;
                    next_s.flag_idle = 1'b1;
                    clear_cnt        = 1'b1;
                end
                if (timeout || early) begin
                    // a running device is reset, not woken
                    next_s.wd_reset  = 1'b1;
                end
            end
            PM_SLEEP, PM_IDLE: begin
                if (timeout) begin
                    // wake only; the core resumes after the power-save
                    next_s.pmode = PM_RUN;
                    next_s.wake  = 1'b1;
                    clear_cnt    = 1'b1;
                    ev[IRQ_WAKE_BIT] = 1'b1;
                end else if (i_evt.wake_event) begin
                    next_s.pmode = PM_RUN;
                    clear_cnt    = 1'b1;
                end
            end
            default: begin
                // illegal code: fall back to running
                next_s.pmode = PM_RUN;
                clear_cnt    = 1'b1;
            end
        endcase

        // device reset returns to run and drops the soft enable
        if (i_evt.dev_rst) begin
            next_s.pmode   = PM_RUN;
            next_s.soft_en = 1'b0;
        end

        // counter update
        if (clear_cnt) begin
            next_s.pre_cnt  = '0;
            next_s.post_cnt = '0;
        end else if (pre_tick) begin
            next_s.pre_cnt  = '0;
            next_s.post_cnt = s.post_cnt + POST_CNT_W'(1);
        end else if (wd_en && rco_tick) begin
            next_s.pre_cnt = s.pre_cnt + PRE_CNT_W'(1);
        end

        // events for the interrupt status
        ev[IRQ_TIMEOUT_BIT] = timeout;
        ev[IRQ_EARLY_BIT]   = early;

        // --- axi4-lite write channel ---
        if (i_axi.awvalid && s.axi.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = i_axi.awaddr;
        end
        if (i_axi.wvalid && s.axi.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = i_axi.wdata;
            next_s.wstrb = i_axi.wstrb;
        end
        if (s.axi.bvalid && i_axi.bready) begin
            next_s.axi.bvalid = 1'b0;
        end
        // commit once both halves are held and no answer is pending
        if (s.aw_got && s.w_got && !s.axi.bvalid) begin
            next_s.aw_got     = 1'b0;
            next_s.w_got      = 1'b0;
            next_s.axi.bvalid = 1'b1;
            next_s.axi.bresp  = addr_mapped(s.awaddr) ? RESP_OKAY
                                                      : RESP_SLVERR;
            // all fields live in byte lane 0
            if (s.wstrb[0]) begin
                if (addr_is(s.awaddr, REG_RESET_CAUSE)) begin
                    wr_rc = 1'b1;
                end
                if (addr_is(s.awaddr, REG_IRQ_MASK)) begin
                    next_s.irq_mask = s.wdata[IRQ_W-1:0];
                end
            end
        end

        // writing zero clears a flag; a hardware set below still wins
        if (wr_rc) begin
            if (!i_evt.dev_rst) begin
                next_s.soft_en = s.wdata[RC_SOFT_EN_BIT];
            end
            if (!s.wdata[RC_TIMEOUT_BIT]) begin
                next_s.flag_tmo = 1'b0;
            end
            if (!s.wdata[RC_SLEEP_BIT] && !i_evt.psave_sleep) begin
                next_s.flag_sleep = 1'b0;
            end
            if (!s.wdata[RC_IDLE_BIT] && !i_evt.psave_idle) begin
                next_s.flag_idle = 1'b0;
            end
        end
        // timeout flag is set by any watchdog expiry or early clear
        if (timeout || early) begin
            next_s.flag_tmo = 1'b1;
        end

        // --- axi4-lite read channel ---
        if (s.axi.rvalid && i_axi.rready) begin
            next_s.axi.rvalid = 1'b0;
        end
        if (i_axi.arvalid && s.axi.arready) begin
            if (addr_is(i_axi.araddr, REG_RESET_CAUSE)) begin
                rd[RC_SOFT_EN_BIT] = s.soft_en;
                rd[RC_TIMEOUT_BIT] = s.flag_tmo;
                rd[RC_SLEEP_BIT]   = s.flag_sleep;
                rd[RC_IDLE_BIT]    = s.flag_idle;
            end else if (addr_is(i_axi.araddr, REG_CONFIG)) begin
                rd[7:0] = s.cfg;
            end else if (addr_is(i_axi.araddr, REG_COUNT)) begin
                rd[21:0] = {s.post_cnt, s.pre_cnt};
            end else if (addr_is(i_axi.araddr, REG_IRQ_STATUS)) begin
                rd[IRQ_W-1:0] = s.irq_stat;
                rd_clr        = 1'b1;
            end else if (addr_is(i_axi.araddr, REG_IRQ_MASK)) begin
                rd[IRQ_W-1:0] = s.irq_mask;
            end
            next_s.axi.rvalid = 1'b1;
            next_s.axi.rdata  = rd;
            next_s.axi.rresp  = addr_mapped(i_axi.araddr) ? RESP_OKAY
                                                          : RESP_SLVERR;
        end

        // read clears status, then new events set it again
        next_s.irq_stat = (rd_clr ? '0 : s.irq_stat) | ev;
        next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);

        // ready flags track the held halves and pending answers
        next_s.axi.awready = !next_s.aw_got && !next_s.axi.bvalid;
        next_s.axi.wready  = !next_s.w_got && !next_s.axi.bvalid;
        next_s.axi.arready = !next_s.axi.rvalid;
    end

    // state register; power-on reset restores every default
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s          <= '0;
            s.cfg_meta <= CFG_RST;
            s.cfg_sync <= CFG_RST;
            s.cfg      <= CFG_RST;
            s.pmode    <= PM_RUN;
            s.irq_mask <= IRQ_MASK_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flops
    assign o_axi       = s.axi;
    assign o_wd_reset  = s.wd_reset;
    assign o_wake      = s.wake;
    assign o_rco_en    = s.rco_en;
    assign o_irq       = s.irq;

endmodule : wdtu_watchdog_timer
